// ==== reset_irq_source_unit.sv ====
// Functional notes
// - Supply flag sets on selected trigger condition in interrupt levels only
// - Supply flag clears when disabled or recovered
// - Enabled supply interrupt on each flag set
// - Level codes: off, reset, interrupt, forbidden
// - Watchdog flag set; cleared by power-up, zero-write
// - Pin reset flag set; cleared by power-up, zero-write
// - Power-up flag cleared only by zero-write
// - Sixteen vector entries, entry zero is reset
// - Line 1, pin-change 2/3, supply 0xA
// - Detection works even when pins drive outputs
// - Masked pin toggle raises pin-change request
// - Pin-change wake works without I/O clock
// - Line supports falling, rising, low level
// - Level mode requests while pin stays low
// - Edge detection needs running I/O clock
// - Low level wakes device asynchronously
// - Level gone before start-up: no request
// - Sense codes: low, any, falling, rising
// - Line and pin-change flags clear on service or one-write
`include "reset_irq_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module reset_irq_source_unit (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Asynchronous pins and analog / reset events
    input wire logic ext_irq_line,
    input wire logic [11:0] pin_change_inputs,
    input wire logic supply_below_level,
    input wire logic io_clk_running,
    input wire reset_irq_pkg::reset_events_t reset_events,
    // Core side
    input wire logic core_awake,
    input wire logic [15:0] periph_irq,
    input wire logic irq_ack,
    input wire logic [3:0] ack_vector,
    output reset_irq_pkg::irq_out_t irq,
    output logic wake_request,
    output logic supply_por_req
);

    // Synchronisers: first stage feeds only the second
    logic [15:0] meta_ff;
    logic [15:0] sync_ff;
    logic [15:0] prev_ff;
    wire [15:0] raw_in = {reset_events.wdt, reset_events.pin, io_clk_running,
                          supply_below_level, pin_change_inputs};

    // Pins are sampled from the pad, so direction does not matter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 16'h0fff;
            sync_ff <= 16'h0fff;
            prev_ff <= 16'h0fff;
        end else begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Line has its own chain; idle high so release does not look like an edge
    logic ext_meta_ff;
    logic ext_s_ff;
    logic ext_d_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_ff <= 1'b1;
            ext_s_ff <= 1'b1;
            ext_d_ff <= 1'b1;
        end else begin
            ext_meta_ff <= ext_irq_line;
            ext_s_ff <= ext_meta_ff;
            ext_d_ff <= ext_s_ff;
        end
    end

    wire [11:0] pins_s = sync_ff[11:0];
    wire [11:0] pins_d = prev_ff[11:0];
    wire trig_s = sync_ff[12];
    wire io_run_s = sync_ff[13];
    wire pin_rise = sync_ff[14] & ~prev_ff[14];
    wire wdt_rise = sync_ff[15] & ~prev_ff[15];

    // Register state
    logic [7:0] pc_mask_low_ff;
    logic [3:0] pc_mask_high_ff;
    logic [1:0] pc_flag_ff;
    logic [1:0] pc_en_ff;
    logic ext_en_ff;
    logic ext_flag_ff;
    reset_irq_pkg::sense_t sense_ff;
    logic sm_flag_ff;
    logic sm_ie_ff;
    logic [2:0] sm_level_ff;
    logic sm_pend_ff;
    logic rc_wdt_ff;
    logic rc_pin_ff;
    logic rc_por_ff;
    logic [31:0] prdata_ff;
    logic por_req_ff;
    reset_irq_pkg::irq_out_t irq_ff;

    // Bus decode; zero wait states, so every access phase completes
    wire [5:0] idx = paddr[7:2];
    wire hit_pcml = idx == `IDX_PC_MASK_LOW;
    wire hit_pcmh = idx == `IDX_PC_MASK_HIGH;
    wire hit_pcf = idx == `IDX_PC_FLAGS;
    wire hit_pce = idx == `IDX_PC_ENABLE;
    wire hit_exe = idx == `IDX_EXT_ENABLE;
    wire hit_exf = idx == `IDX_EXT_FLAGS;
    wire hit_exs = idx == `IDX_EXT_SENSE;
    wire hit_sm = idx == `IDX_SUPPLY_CTRL;
    wire hit_rc = idx == `IDX_RESET_CAUSE;
    wire addr_hit = hit_pcml | hit_pcmh | hit_pcf | hit_pce | hit_exe | hit_exf
                    | hit_exs | hit_sm | hit_rc;
    wire acc = psel & penable;
    wire wr = acc & pwrite & addr_hit;
    wire setup_rd = psel & ~penable & ~pwrite;
    wire wr_pcf = wr & hit_pcf;
    wire wr_exf = wr & hit_exf;
    wire wr_sm = wr & hit_sm;
    wire wr_rc = wr & hit_rc;
    wire [7:0] wb = pwdata[7:0];

    assign pready = 1'b1;
    assign pslverr = acc & ~addr_hit;
    assign prdata = prdata_ff;

    // Read selection; unused bits read as zero
    wire [7:0] rd_sm = {sm_flag_ff, sm_ie_ff, 3'h0, sm_level_ff};
    wire [7:0] rd_rc = {4'h0, rc_wdt_ff, 1'b0, rc_pin_ff, rc_por_ff};
    wire [7:0] rd_byte = hit_pcml ? pc_mask_low_ff :
                         hit_pcmh ? {4'h0, pc_mask_high_ff} :
                         hit_pcf ? {6'h00, pc_flag_ff} :
                         hit_pce ? {6'h00, pc_en_ff} :
                         hit_exe ? {7'h00, ext_en_ff} :
                         hit_exf ? {7'h00, ext_flag_ff} :
                         hit_exs ? {6'h00, sense_ff} :
                         hit_sm ? rd_sm :
                         hit_rc ? rd_rc : `RST_BYTE;

    // Read data is latched in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (setup_rd) begin
            prdata_ff <= {24'h000000, rd_byte};
        end
    end

    // Plain control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_mask_low_ff <= `RST_BYTE;
            pc_mask_high_ff <= 4'h0;
            pc_en_ff <= 2'h0;
            ext_en_ff <= 1'b0;
            sense_ff <= reset_irq_pkg::SENSE_LOW;
        end else if (wr) begin
            if (hit_pcml) pc_mask_low_ff <= wb;
            if (hit_pcmh) pc_mask_high_ff <= wb[3:0];
            if (hit_pce) pc_en_ff <= wb[1:0];
            if (hit_exe) ext_en_ff <= wb[0];
            if (hit_exs) sense_ff <= reset_irq_pkg::sense_t'(wb[1:0]);
        end
    end

    // Service acknowledges from the core
    wire ack_ext = irq_ack & (ack_vector == `VEC_EXT);
    wire ack_pcl = irq_ack & (ack_vector == `VEC_PC_LOW);
    wire ack_pch = irq_ack & (ack_vector == `VEC_PC_HIGH);
    wire ack_sm = irq_ack & (ack_vector == `VEC_SUPPLY);

    // Pin-change detection per mask bit
    wire [11:0] pc_mask = {pc_mask_high_ff, pc_mask_low_ff};
    wire [11:0] chg = (pins_s ^ pins_d) & pc_mask;
    wire [1:0] pc_hit = {|chg[11:8], |chg[7:0]};
    wire [1:0] pc_clr = ({ack_pch, ack_pcl} | (wr_pcf ? wb[1:0] : 2'h0));
    wire [1:0] nxt_pc_flag = pc_hit | (pc_flag_ff & ~pc_clr);

    // Line sense decode; edges need the I/O clock
    wire ext_level_mode = sense_ff == reset_irq_pkg::SENSE_LOW;
    wire ext_any = ext_s_ff ^ ext_d_ff;
    wire ext_fall = ext_d_ff & ~ext_s_ff;
    wire ext_rise = ~ext_d_ff & ext_s_ff;
    wire ext_edge = (sense_ff == reset_irq_pkg::SENSE_ANY) ? ext_any :
                    (sense_ff == reset_irq_pkg::SENSE_FALL) ? ext_fall :
                    (sense_ff == reset_irq_pkg::SENSE_RISE) ? ext_rise : 1'b0;
    wire ext_hit = io_run_s & ext_edge;
    wire ext_clr = ack_ext | (wr_exf & wb[0]);
    // Flag is held clear in level mode; set beats clear
    wire nxt_ext_flag = ~ext_level_mode & (ext_hit | (ext_flag_ff & ~ext_clr));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_flag_ff <= 2'h0;
            ext_flag_ff <= 1'b0;
        end else begin
            pc_flag_ff <= nxt_pc_flag;
            ext_flag_ff <= nxt_ext_flag;
        end
    end

    // Supply monitor level decode
    wire sm_irq_mode = (sm_level_ff == `LVL_IRQ_LO) | (sm_level_ff == `LVL_IRQ_HI);
    wire sm_por_mode = (sm_level_ff == `LVL_POR_LO) | (sm_level_ff == `LVL_POR_HI);
    wire sm_level_ok = wb[2:0] <= `LVL_IRQ_HI;
    // Flag follows the trigger in interrupt modes only
    wire nxt_sm_flag = sm_irq_mode & trig_s;
    wire sm_rise = nxt_sm_flag & ~sm_flag_ff;
    // One pending request per flag set while enabled
    wire nxt_sm_pend = (sm_rise & sm_ie_ff) | (sm_pend_ff & ~ack_sm);

    // Forbidden level codes are ignored, keeping the old level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sm_ie_ff <= 1'b0;
            sm_level_ff <= `LVL_OFF;
        end else if (wr_sm) begin
            sm_ie_ff <= wb[`SM_IE_BIT];
            if (sm_level_ok) sm_level_ff <= wb[2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sm_flag_ff <= 1'b0;
            sm_pend_ff <= 1'b0;
            por_req_ff <= 1'b0;
        end else begin
            sm_flag_ff <= nxt_sm_flag;
            sm_pend_ff <= nxt_sm_pend;
            por_req_ff <= sm_por_mode & trig_s;
        end
    end

    // Reset cause flags; writing one leaves a flag alone
    wire rc_wdt_clr = wr_rc & ~wb[`RC_WDT_BIT];
    wire rc_pin_clr = wr_rc & ~wb[`RC_PIN_BIT];
    wire rc_por_clr = wr_rc & ~wb[`RC_POR_BIT];
    wire nxt_rc_wdt = wdt_rise | (rc_wdt_ff & ~rc_wdt_clr);
    wire nxt_rc_pin = pin_rise | (rc_pin_ff & ~rc_pin_clr);
    wire nxt_rc_por = rc_por_ff & ~rc_por_clr;

    // Reset image of the cause register; single bits are picked from it
    localparam logic [7:0] rc_reset_val = `RST_CAUSE;

    // Power-on reset is presetn: it sets the power-up flag, clears the rest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_wdt_ff <= rc_reset_val[`RC_WDT_BIT];
            rc_pin_ff <= rc_reset_val[`RC_PIN_BIT];
            rc_por_ff <= rc_reset_val[`RC_POR_BIT];
        end else begin
            rc_wdt_ff <= nxt_rc_wdt;
            rc_pin_ff <= nxt_rc_pin;
            rc_por_ff <= nxt_rc_por;
        end
    end

    // Level request only while the core is up and the pin is still low;
    // a pulse that ends during start-up leaves nothing behind
    wire ext_level_req = ext_en_ff & ext_level_mode & ~ext_s_ff & core_awake;
    wire ext_req = ext_level_req | (ext_en_ff & ext_flag_ff);
    wire [1:0] pc_req = pc_flag_ff & pc_en_ff;

    // Vector map: own sources replace the peripheral inputs
    logic [15:0] own_req;
    always_comb begin
        own_req = 16'h0000;
        own_req[`VEC_EXT] = ext_req;
        own_req[`VEC_PC_LOW] = pc_req[0];
        own_req[`VEC_PC_HIGH] = pc_req[1];
        own_req[`VEC_SUPPLY] = sm_pend_ff;
    end
    wire [15:0] pend = (periph_irq & ~`VEC_OWN_MASK) | own_req;

    // Lowest set entry wins
    function automatic logic [3:0] lowest(input logic [15:0] p);
        logic [3:0] r;
        r = `VEC_RESET;
        for (int i = 15; i >= 0; i--) begin
            if (p[i]) r = 4'(i);
        end
        return r;
    endfunction

    wire [3:0] nxt_vec = lowest(pend);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= '0;
        end else begin
            irq_ff.req <= |pend;
            irq_ff.vector <= nxt_vec;
        end
    end

    assign irq = irq_ff;
    assign supply_por_req = por_req_ff;

    // Wake path is combinational from the pads, so it works with every
    // clock stopped; the low level must persist through start-up
    wire wake_pc = |((pin_change_inputs ^ pins_s) & pc_mask);
    wire wake_lvl = ext_en_ff & ext_level_mode & ~ext_irq_line;
    assign wake_request = wake_pc | wake_lvl;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wdt_zero_write;
        rc_wdt_clr && !wdt_rise;
    endsequence

    a_supply_flag_set: assert property (sm_irq_mode && trig_s |=> sm_flag_ff)
        else $error("supply flag not set on trigger");
    a_supply_flag_off: assert property ((sm_level_ff == `LVL_OFF) |=> !sm_flag_ff)
        else $error("supply flag kept while disabled");
    a_supply_irq_pend: assert property (sm_rise && sm_ie_ff |=> sm_pend_ff ##1 irq_ff.req)
        else $error("supply interrupt not raised");
    a_wdt_flag_clear: assert property (s_wdt_zero_write |=> !rc_wdt_ff)
        else $error("watchdog flag not cleared by zero write");
    a_pin_flag_set: assert property (pin_rise |=> rc_pin_ff)
        else $error("pin reset flag not set");
    a_por_flag_hold: assert property ($fell(rc_por_ff) |-> $past(rc_por_clr))
        else $error("power-up flag cleared without write");
    a_pc_flag_set: assert property (pc_hit[0] |=> pc_flag_ff[0])
        else $error("pin-change flag missed a toggle");
    a_edge_no_clock: assert property (!io_run_s && !ext_flag_ff |=> !ext_flag_ff)
        else $error("edge seen with I/O clock stopped");
    a_level_request: assert property (ext_level_req |=> irq_ff.req && irq_ff.vector == `VEC_EXT)
        else $error("level request not presented");
    a_level_flag_zero: assert property (ext_level_mode |=> !ext_flag_ff)
        else $error("line flag set in level mode");
    a_ack_clears_pc: assert property (ack_pcl && !pc_hit[0] |=> !pc_flag_ff[0])
        else $error("service did not clear pin-change flag");
    a_prio_lowest: assert property (pend[`VEC_EXT] |=> irq_ff.vector == `VEC_EXT)
        else $error("lower vector not preferred");

    // Edge detection steps: I/O clock up and the selected edge seen
    sequence s_line_fall;
        io_run_s && ext_fall && (sense_ff == reset_irq_pkg::SENSE_FALL);
    endsequence

    sequence s_line_any;
        io_run_s && ext_any && (sense_ff == reset_irq_pkg::SENSE_ANY);
    endsequence

    // Level wake is armed straight from the pad, no clock needed
    sequence s_level_armed;
        ext_en_ff && ext_level_mode && !ext_irq_line;
    endsequence

    sequence s_pin_zero_write;
        rc_pin_clr && !pin_rise;
    endsequence

    a_line_fall_flag: assert property (s_line_fall |=> ext_flag_ff)
        else $error("falling edge did not set line flag");
    a_line_any_flag: assert property (s_line_any |=> ext_flag_ff)
        else $error("line change did not set line flag");
    a_line_sw_clear: assert property (wr_exf && wb[0] && !ext_hit |=> !ext_flag_ff)
        else $error("line flag not cleared by one write");
    a_level_wake: assert property (s_level_armed |-> wake_request)
        else $error("low level did not request wake");
    a_por_req_level: assert property (sm_por_mode && trig_s |=> supply_por_req)
        else $error("reset level did not request reset");
    a_por_no_flag: assert property (sm_por_mode |=> !sm_flag_ff)
        else $error("supply flag set in reset level");
    a_pin_flag_clear: assert property (s_pin_zero_write |=> !rc_pin_ff)
        else $error("pin reset flag not cleared by zero write");
    a_vector_not_reset: assert property (irq_ff.req |-> irq_ff.vector != `VEC_RESET)
        else $error("reset entry presented as a request");

endmodule // reset_irq_source_unit

`default_nettype wire

// ==== reset_irq_defs.svh ====
`ifndef RESET_IRQ_DEFS_SVH
`define RESET_IRQ_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_PC_MASK_LOW 6'h0f
`define IDX_PC_MASK_HIGH 6'h10
`define IDX_PC_FLAGS 6'h11
`define IDX_PC_ENABLE 6'h12
`define IDX_EXT_ENABLE 6'h13
`define IDX_EXT_FLAGS 6'h14
`define IDX_EXT_SENSE 6'h15
`define IDX_SUPPLY_CTRL 6'h34
`define IDX_RESET_CAUSE 6'h3b

// Field positions
`define SM_FLAG_BIT 7
`define SM_IE_BIT 6
`define RC_WDT_BIT 3
`define RC_PIN_BIT 1
`define RC_POR_BIT 0

// Supply trigger level codes
`define LVL_OFF 3'h0
`define LVL_POR_LO 3'h1
`define LVL_POR_HI 3'h2
`define LVL_IRQ_LO 3'h3
`define LVL_IRQ_HI 3'h4

// Vector entries (program addresses)
`define VEC_RESET 4'h0
`define VEC_EXT 4'h1
`define VEC_PC_LOW 4'h2
`define VEC_PC_HIGH 4'h3
`define VEC_SUPPLY 4'ha
`define VEC_OWN_MASK 16'h040f

// Reset values
`define RST_BYTE 8'h00
`define RST_CAUSE 8'h01

`endif

// ==== reset_irq_pkg.sv ====
package reset_irq_pkg;

    // External line sense select, in field order
    typedef enum logic [1:0] {SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE} sense_t;

    // Request presented to the core's dispatch
    typedef struct packed {
        logic req;
        logic [3:0] vector;
    } irq_out_t;

    // Reset causes other than power-on, from the reset logic
    typedef struct packed {
        logic wdt;
        logic pin;
    } reset_events_t;

endpackage

// ==== reset_irq_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none

module reset_irq_far_side (
    // Clock
    input wire logic pclk,
    // Pins, supply and reset events
    output logic ext_irq_line,
    output logic [11:0] pin_change_inputs,
    output logic supply_below_level,
    output logic io_clk_running,
    output reset_irq_pkg::reset_events_t reset_events,
    // Core dispatch
    output logic core_awake,
    output logic irq_ack,
    output logic [3:0] ack_vector
);
    // Idle: pulled-up pins high, no events, core running
    initial begin
        ext_irq_line = 1'b1;
        pin_change_inputs = 12'hfff;
        supply_below_level = 1'b0;
        io_clk_running = 1'b1;
        reset_events = '0;
        core_awake = 1'b1;
        irq_ack = 1'b0;
        ack_vector = 4'h0;
    end

    // New pin and supply levels, just after an edge
    task drive(input logic line, input logic [11:0] pins, input logic trig, input logic io);
        @(posedge pclk);
        ext_irq_line <= line;
        pin_change_inputs <= pins;
        supply_below_level <= trig;
        io_clk_running <= io;
    endtask

    // One-cycle service pulse; vector is scrambled after so no stale value lingers
    task ack(input logic [3:0] v);
        @(posedge pclk);
        irq_ack <= 1'b1;
        ack_vector <= v;
        @(posedge pclk);
        irq_ack <= 1'b0;
        ack_vector <= ~v;
    endtask

    // Held long enough to pass the synchroniser
    task reset_event(input logic wdt);
        @(posedge pclk);
        reset_events.wdt <= wdt;
        reset_events.pin <= !wdt;
        repeat (3) @(posedge pclk);
        reset_events <= '0;
    endtask

    // Low level wakes the sleeping core; with hold the line stays low past start-up
    task level_wake(input logic hold);
        @(posedge pclk);
        core_awake <= 1'b0;
        ext_irq_line <= 1'b0;
        @(posedge pclk);
        ext_irq_line <= !hold;
        repeat (4) @(posedge pclk);
        core_awake <= 1'b1;
    endtask
endmodule // reset_irq_far_side

`default_nettype wire

// ==== tb.sv ====
`include "reset_irq_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic wake_request, supply_por_req, ext_irq_line, supply_below_level;
    logic io_clk_running, core_awake, irq_ack;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] periph_irq;
    logic [11:0] pin_change_inputs;
    logic [3:0] ack_vector;
    reset_irq_pkg::reset_events_t reset_events;
    reset_irq_pkg::irq_out_t irq;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;

    reset_irq_source_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_line(ext_irq_line),
        .pin_change_inputs(pin_change_inputs), .supply_below_level(supply_below_level),
        .io_clk_running(io_clk_running), .reset_events(reset_events),
        .core_awake(core_awake), .periph_irq(periph_irq), .irq_ack(irq_ack),
        .ack_vector(ack_vector), .irq(irq), .wake_request(wake_request),
        .supply_por_req(supply_por_req));

    reset_irq_far_side u_far (.pclk(pclk), .ext_irq_line(ext_irq_line),
        .pin_change_inputs(pin_change_inputs), .supply_below_level(supply_below_level),
        .io_clk_running(io_clk_running), .reset_events(reset_events),
        .core_awake(core_awake), .irq_ack(irq_ack), .ack_vector(ack_vector));

    // 10 MHz clock
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            stop_test();
        end
    end

    // One APB transfer; waits for pready rather than assuming zero wait states
    task apb(input logic [5:0] idx, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task rdchk(input logic [5:0] idx, input logic [31:0] e, input string nm);
        apb(idx, 1'b0, 8'h00);
        chk(nm, e, rd);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        periph_irq = 16'h0;
        cyc(4);
        presetn <= 1'b1;
        // Reset values, then an unmapped place
        rdchk(`IDX_RESET_CAUSE, 32'h01, "reset_cause");
        rdchk(`IDX_SUPPLY_CTRL, 32'h00, "supply_ctrl");
        apb(6'h20, 1'b1, 8'hff);
        chk("pslverr", 32'h1, {31'h0, serr});
        rdchk(6'h20, 32'h0, "unmapped");
        // Reset causes: zero-write clears, one-write keeps
        u_far.reset_event(1'b1);
        u_far.reset_event(1'b0);
        cyc(4);
        rdchk(`IDX_RESET_CAUSE, 32'h0b, "reset_cause");
        apb(`IDX_RESET_CAUSE, 1'b1, 8'h0a);
        rdchk(`IDX_RESET_CAUSE, 32'h0a, "reset_cause");
        apb(`IDX_RESET_CAUSE, 1'b1, 8'h08);
        rdchk(`IDX_RESET_CAUSE, 32'h08, "reset_cause");
        apb(`IDX_RESET_CAUSE, 1'b1, 8'h00);
        rdchk(`IDX_RESET_CAUSE, 32'h00, "reset_cause");
        $display("test reset_cause finished");
        // Every reset and interrupt level code (1 to 4), with the interrupt enabled
        for (int c = 1; c <= 4; c++) begin
            apb(`IDX_SUPPLY_CTRL, 1'b1, {5'b01000, c[2:0]});
            u_far.drive(1'b1, 12'hfff, 1'b1, 1'b1);
            cyc(6);
            chk("supply_por_req", {31'h0, c <= 2}, {31'h0, supply_por_req});
            chk("irq", (c >= 3) ? 32'h1a : 32'h0, {27'h0, irq});
            rdchk(`IDX_SUPPLY_CTRL, {24'h0, c >= 3, 4'b1000, c[2:0]}, "supply_ctrl");
            if (c >= 3) u_far.ack(`VEC_SUPPLY);
            u_far.drive(1'b1, 12'hfff, 1'b0, 1'b1);
            cyc(6);
            chk("irq", 32'h0, {27'h0, irq});
            rdchk(`IDX_SUPPLY_CTRL, {24'h0, 5'b01000, c[2:0]}, "supply_ctrl");
        end
        // Disabling while triggered clears the flag; forbidden code leaves the level
        u_far.drive(1'b1, 12'hfff, 1'b1, 1'b1);
        cyc(6);
        apb(`IDX_SUPPLY_CTRL, 1'b1, 8'h40);
        cyc(3);
        rdchk(`IDX_SUPPLY_CTRL, 32'h40, "supply_ctrl");
        u_far.ack(`VEC_SUPPLY);
        apb(`IDX_SUPPLY_CTRL, 1'b1, 8'h45);
        rdchk(`IDX_SUPPLY_CTRL, 32'h40, "supply_ctrl");
        u_far.drive(1'b1, 12'hfff, 1'b0, 1'b1);
        $display("test supply_monitor finished");
        // Pin change: pin 0 and pin 11 enabled, pin 1 masked off
        apb(`IDX_PC_MASK_LOW, 1'b1, 8'h01);
        apb(`IDX_PC_MASK_HIGH, 1'b1, 8'h08);
        apb(`IDX_PC_ENABLE, 1'b1, 8'h03);
        u_far.drive(1'b1, 12'hffd, 1'b0, 1'b1);
        cyc(6);
        rdchk(`IDX_PC_FLAGS, 32'h0, "pc_flags");
        u_far.drive(1'b1, 12'hffc, 1'b0, 1'b1);
        @(negedge pclk);
        chk("wake_request", 32'h1, {31'h0, wake_request});
        cyc(6);
        rdchk(`IDX_PC_FLAGS, 32'h1, "pc_flags");
        periph_irq <= 16'h0201;
        cyc(3);
        chk("irq", 32'h12, {27'h0, irq});
        apb(`IDX_PC_FLAGS, 1'b1, 8'h01);
        cyc(3);
        chk("irq", 32'h19, {27'h0, irq});
        periph_irq <= 16'h0;
        u_far.drive(1'b1, 12'h7fc, 1'b0, 1'b1);
        cyc(6);
        chk("irq", 32'h13, {27'h0, irq});
        u_far.ack(`VEC_PC_HIGH);
        cyc(2);
        rdchk(`IDX_PC_FLAGS, 32'h0, "pc_flags");
        $display("test pin_change finished");
        // Edge sense codes: any, falling, rising
        apb(`IDX_EXT_ENABLE, 1'b1, 8'h01);
        for (int s = 1; s <= 3; s++) begin
            apb(`IDX_EXT_SENSE, 1'b1, s[7:0]);
            u_far.drive(1'b0, 12'h7fc, 1'b0, 1'b1);
            cyc(6);
            rdchk(`IDX_EXT_FLAGS, {31'h0, s != 3}, "line_flag");
            apb(`IDX_EXT_FLAGS, 1'b1, 8'h01);
            u_far.drive(1'b1, 12'h7fc, 1'b0, 1'b1);
            cyc(6);
            rdchk(`IDX_EXT_FLAGS, {31'h0, s != 2}, "line_flag");
            apb(`IDX_EXT_FLAGS, 1'b1, 8'h01);
        end
        // Falling edge with the I/O clock halted is not seen
        apb(`IDX_EXT_SENSE, 1'b1, 8'h02);
        u_far.drive(1'b1, 12'h7fc, 1'b0, 1'b0);
        u_far.drive(1'b0, 12'h7fc, 1'b0, 1'b0);
        cyc(6);
        rdchk(`IDX_EXT_FLAGS, 32'h0, "line_flag");
        u_far.drive(1'b1, 12'h7fc, 1'b0, 1'b1);
        $display("test line_edges finished");
        // Low level: short pulse wakes without request, held level requests
        apb(`IDX_EXT_SENSE, 1'b1, 8'h00);
        u_far.level_wake(1'b0);
        cyc(6);
        chk("irq", 32'h0, {27'h0, irq});
        u_far.level_wake(1'b1);
        chk("wake_request", 32'h1, {31'h0, wake_request});
        cyc(3);
        chk("irq", 32'h11, {27'h0, irq});
        cyc(5);
        chk("irq", 32'h11, {27'h0, irq});
        u_far.drive(1'b1, 12'h7fc, 1'b0, 1'b1);
        cyc(5);
        chk("irq", 32'h0, {27'h0, irq});
        $display("test line_level finished");
        // Power-up reset in mid-run clears the other causes, sets its own
        u_far.reset_event(1'b1);
        u_far.reset_event(1'b0);
        cyc(4);
        rdchk(`IDX_RESET_CAUSE, 32'h0a, "reset_cause");
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        rdchk(`IDX_RESET_CAUSE, 32'h01, "reset_cause");
        $display("test power_up_reset finished");
        stop_test();
    end
endmodule // tb

`default_nettype wire
